// ===== pkg/xip_consts.svh
// Purpose: named constants of the execute-in-place read engine
// Assumes: included by bare name wherever a figure is needed
// Notes:   definitions only
`ifndef XIP_CONSTS_SVH
`define XIP_CONSTS_SVH

// ********************************************************
// protocol codes and lane counts
// ********************************************************
`define MODE_SINGLE    2'h0
`define MODE_DUAL      2'h1
`define MODE_QUAD      2'h2
`define LANES_1        3'h1
`define LANES_2        3'h2
`define LANES_4        3'h4
`define OE_LANES_1     4'h2
`define OE_LANES_2     4'h3
`define OE_LANES_4     4'hF

// ********************************************************
// command codes that count as fast reads
// ********************************************************
`define CMD_FAST_READ  8'h0B
`define CMD_DUAL_OUT   8'h3B
`define CMD_DUAL_IO    8'hBB
`define CMD_QUAD_OUT   8'h6B
`define CMD_QUAD_IO    8'hEB

// ********************************************************
// field sizes, reset values, counts
// ********************************************************
`define CMD_BITS       8
`define ADDR_BITS      24
`define BYTE_BITS      8
`define MIN_DUMMY      4'h1
`define NVCR_XIP_OFF   3'h7
`define VCR_XIP_RESET  1'h1
`define IDLE_BYTE      8'hFF
`define PINS_IDLE      7'h3F
`define FIFO_WIDTH     8
`define FIFO_DEPTH     8
`define CNT_ZERO       5'h00
`define CNT_ONE        5'h01

`endif

// ===== pkg/xip_pkg.sv
// Purpose: types shared by the execute-in-place read engine
// Assumes: nothing
// Notes:   constants live in xip_consts.svh
package xip_pkg;

    // ********************************************************
    // transfer phases, gray along idle-cmd-addr-dummy-data
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b011,
        ST_DUMMY = 3'b010,
        ST_DATA  = 3'b110,
        ST_SKIP  = 3'b111
    } xfer_state_t;

    // ********************************************************
    // pin group and static configuration
    // ********************************************************
    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic       hw_rst_n;
        logic [3:0] io;
    } pins_t;

    typedef struct packed {
        logic [1:0] protocol;
        logic       basic_xip;
        logic [2:0] nvcr_xip;
        logic       rst_pin_en;
        logic [3:0] dummy;
    } cfg_t;

endpackage

// ===== verilog/xip_read_engine.sv
// Purpose: device-side execute-in-place read engine of a serial flash
// Assumes: serial clock, select and data lines sampled on sys_clk
// Notes:   read bytes arrive from the array side through a small fifo
`include "xip_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// ********************************************************
// byte fifo between array side and serial output
// ********************************************************
module xip_byte_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             not_full_ff;
    logic             not_empty_ff;
    wire              push = in_valid & not_full_ff;
    wire              pop = out_ready & not_empty_ff;
    wire  [AW:0]      nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    wire  [AW:0]      depth_w = (AW+1)'(DEPTH);

    assign in_ready  = not_full_ff;
    assign out_valid = not_empty_ff;
    assign out_data  = mem[rd_ptr_ff];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // flush drops what the last select left behind
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            not_full_ff  <= 1'b1;
            not_empty_ff <= 1'b0;
        end else if (flush) begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            not_full_ff  <= 1'b1;
            not_empty_ff <= 1'b0;
        end else begin
            wr_ptr_ff    <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff    <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff     <= nxt_count;
            not_full_ff  <= nxt_count != depth_w;
            not_empty_ff <= nxt_count != '0;
        end
    end
endmodule

// ********************************************************
// read engine top
// ********************************************************
module xip_read_engine (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire xip_pkg::pins_t pins,
    input  wire xip_pkg::cfg_t cfg,
    input  wire logic          vcr_wr,
    input  wire logic          vcr_wr_xip,
    input  wire logic [7:0]    rd_data,
    input  wire logic          rd_valid,
    output var  logic          rd_ready,
    output var  logic [23:0]   rd_addr,
    output var  logic          rd_addr_valid,
    output var  logic [3:0]    io_out,
    output var  logic [3:0]    io_oe,
    output var  logic          execute_in_place,
    output var  logic          vcr_xip_bit
);

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [2:0] proto_lanes(input logic [1:0] p);
        return (p == `MODE_QUAD) ? `LANES_4 : (p == `MODE_DUAL) ? `LANES_2 : `LANES_1;
    endfunction

    function automatic logic [2:0] cmd_lanes(input logic [7:0] c, input logic [1:0] p);
        if (p != `MODE_SINGLE) begin
            return proto_lanes(p);
        end
        if (c == `CMD_DUAL_OUT || c == `CMD_DUAL_IO) begin
            return `LANES_2;
        end
        if (c == `CMD_QUAD_OUT || c == `CMD_QUAD_IO) begin
            return `LANES_4;
        end
        return `LANES_1;
    endfunction

    function automatic logic is_fast_read(input logic [7:0] c);
        return c == `CMD_FAST_READ || c == `CMD_DUAL_OUT || c == `CMD_DUAL_IO ||
               c == `CMD_QUAD_OUT || c == `CMD_QUAD_IO;
    endfunction

    function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                             input logic [2:0] lanes);
        if (lanes == `LANES_4) begin
            return {sh[19:0], io};
        end
        if (lanes == `LANES_2) begin
            return {sh[21:0], io[1:0]};
        end
        return {sh[22:0], io[0]};
    endfunction

    function automatic logic [4:0] edges_of(input int bits, input logic [2:0] lanes);
        return 5'(bits / int'(lanes));
    endfunction

    function automatic logic [3:0] oe_mask(input logic [2:0] lanes);
        return (lanes == `LANES_4) ? `OE_LANES_4 :
               (lanes == `LANES_2) ? `OE_LANES_2 : `OE_LANES_1;
    endfunction

    // single lane data leaves on line one, as in plain spi reads
    function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] lanes);
        if (lanes == `LANES_4) begin
            return b[7:4];
        end
        if (lanes == `LANES_2) begin
            return {2'b00, b[7:6]};
        end
        return {2'b00, b[7], 1'b0};
    endfunction

    // ********************************************************
    // pin synchronisers, three stages with agreement filter
    // ********************************************************
    xip_pkg::pins_t sync1_ff;
    xip_pkg::pins_t sync2_ff;
    xip_pkg::pins_t sync3_ff;
    xip_pkg::pins_t filt_ff;
    xip_pkg::pins_t prev_ff;
    wire  [6:0]     nxt_filt = (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff ^ sync3_ff));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_ff <= `PINS_IDLE;
            sync2_ff <= `PINS_IDLE;
            sync3_ff <= `PINS_IDLE;
            filt_ff  <= `PINS_IDLE;
            prev_ff  <= `PINS_IDLE;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff  <= nxt_filt;
            prev_ff  <= filt_ff;
        end
    end

    wire rise = filt_ff.sclk & ~prev_ff.sclk;
    wire fall = ~filt_ff.sclk & prev_ff.sclk;
    wire cs_act = ~filt_ff.cs_n;
    wire cs_fall = ~filt_ff.cs_n & prev_ff.cs_n;
    wire cs_rise = filt_ff.cs_n & ~prev_ff.cs_n;

    // ********************************************************
    // transfer sequencing
    // ********************************************************
    xip_pkg::xfer_state_t state_ff;
    xip_pkg::xfer_state_t nxt_state;
    logic [4:0]  cnt_ff;
    logic [4:0]  nxt_cnt;
    logic [23:0] sh_ff;
    logic [23:0] nxt_sh;
    logic [2:0]  lanes_ff;
    logic [2:0]  nxt_lanes;
    logic        nxt_addr_valid;
    logic        xip_ff;
    logic        nxt_xip;
    logic        vcr_ff;
    logic        nxt_vcr;
    logic        boot_done_ff;
    logic [23:0] rd_addr_ff;
    logic        rd_addr_valid_ff;

    wire [23:0] sh_in = shift_in(sh_ff, filt_ff.io, lanes_ff);
    wire [4:0]  cnt_inc = cnt_ff + `CNT_ONE;
    wire [3:0]  dummy_n = (cfg.dummy < `MIN_DUMMY) ? `MIN_DUMMY : cfg.dummy;
    wire        nvcr_on = cfg.nvcr_xip != `NVCR_XIP_OFF;
    // a reset pulse while selected is ignored
    wire        hwrst_act = cfg.rst_pin_en & ~filt_ff.hw_rst_n & filt_ff.cs_n;
    wire        conf_sample = rise & cs_act & (state_ff == xip_pkg::ST_DUMMY) &
                              (cnt_ff == `CNT_ZERO);
    // only line zero decides; upper lines are don't care
    wire        conf = filt_ff.io[0];

    always_comb begin
        nxt_state      = state_ff;
        nxt_cnt        = cnt_ff;
        nxt_sh         = sh_ff;
        nxt_lanes      = lanes_ff;
        nxt_addr_valid = 1'b0;
        if (cs_fall) begin
            // no opcode is expected while xip holds
            nxt_state = xip_ff ? xip_pkg::ST_ADDR : xip_pkg::ST_CMD;
            nxt_cnt   = `CNT_ZERO;
            nxt_sh    = '0;
            nxt_lanes = proto_lanes(cfg.protocol);
        end else if (cs_rise) begin
            nxt_state = xip_pkg::ST_IDLE;
        end else if (rise & cs_act) begin
            unique case (state_ff)
                xip_pkg::ST_CMD: begin
                    nxt_sh  = sh_in;
                    nxt_cnt = cnt_inc;
                    if (cnt_inc == edges_of(`CMD_BITS, lanes_ff)) begin
                        nxt_cnt   = `CNT_ZERO;
                        nxt_sh    = '0;
                        nxt_lanes = cmd_lanes(sh_in[7:0], cfg.protocol);
                        nxt_state = is_fast_read(sh_in[7:0]) ? xip_pkg::ST_ADDR
                                                             : xip_pkg::ST_SKIP;
                    end
                end
                xip_pkg::ST_ADDR: begin
                    nxt_sh  = sh_in;
                    nxt_cnt = cnt_inc;
                    // 6/12/24 address clocks then the confirm clock give 7/13/25
                    if (cnt_inc == edges_of(`ADDR_BITS, lanes_ff)) begin
                        nxt_state      = xip_pkg::ST_DUMMY;
                        nxt_cnt        = `CNT_ZERO;
                        nxt_addr_valid = 1'b1;
                    end
                end
                xip_pkg::ST_DUMMY: begin
                    nxt_cnt = cnt_inc;
                    if (cnt_inc == {1'b0, dummy_n}) begin
                        nxt_state = xip_pkg::ST_DATA;
                    end
                end
                xip_pkg::ST_IDLE, xip_pkg::ST_DATA, xip_pkg::ST_SKIP: begin
                    nxt_cnt = cnt_ff;
                end
                default: begin
                    nxt_state = xip_pkg::ST_SKIP;
                end
            endcase
        end
        if (hwrst_act) begin
            nxt_state = xip_pkg::ST_IDLE;
        end
    end

    // exit setting the enable bit wins over a software write
    always_comb begin
        nxt_xip = xip_ff;
        nxt_vcr = vcr_wr ? vcr_wr_xip : vcr_ff;
        if (!boot_done_ff) begin
            nxt_xip = nvcr_on;
        end else if (hwrst_act) begin
            nxt_xip = nvcr_on;
            nxt_vcr = `VCR_XIP_RESET;
        end else if (conf_sample) begin
            if (xip_ff) begin
                // recovery ones land here too and touch nothing else
                if (conf) begin
                    nxt_xip = 1'b0;
                    nxt_vcr = `VCR_XIP_RESET;
                end
            end else if (!conf && (!vcr_ff || cfg.basic_xip)) begin
                nxt_xip = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff         <= xip_pkg::ST_IDLE;
            cnt_ff           <= `CNT_ZERO;
            sh_ff            <= '0;
            lanes_ff         <= `LANES_1;
            xip_ff           <= 1'b0;
            vcr_ff           <= `VCR_XIP_RESET;
            boot_done_ff     <= 1'b0;
            rd_addr_ff       <= '0;
            rd_addr_valid_ff <= 1'b0;
        end else begin
            state_ff         <= nxt_state;
            cnt_ff           <= nxt_cnt;
            sh_ff            <= nxt_sh;
            lanes_ff         <= nxt_lanes;
            xip_ff           <= nxt_xip;
            vcr_ff           <= nxt_vcr;
            boot_done_ff     <= 1'b1;
            rd_addr_ff       <= nxt_addr_valid ? sh_in : rd_addr_ff;
            rd_addr_valid_ff <= nxt_addr_valid;
        end
    end

    // ********************************************************
    // data output path
    // ********************************************************
    logic [7:0] out_sh_ff;
    logic [2:0] out_cnt_ff;
    logic [3:0] io_out_ff;
    logic [3:0] io_oe_ff;
    logic       fifo_valid;
    logic [7:0] fifo_data;

    wire       drive_edge = fall & cs_act & (state_ff == xip_pkg::ST_DATA);
    wire       load = drive_edge & (out_cnt_ff == '0);
    // an empty fifo sends idle ones rather than stalling the clock
    wire [7:0] cur_byte = load ? (fifo_valid ? fifo_data : `IDLE_BYTE) : out_sh_ff;
    wire       pop = load & fifo_valid;
    wire [2:0] byte_edges = 3'((`BYTE_BITS / int'(lanes_ff)) - 1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_sh_ff  <= '0;
            out_cnt_ff <= '0;
            io_out_ff  <= '0;
            io_oe_ff   <= '0;
        end else if (cs_rise | cs_fall | hwrst_act) begin
            out_cnt_ff <= '0;
            io_oe_ff   <= '0;
        end else if (drive_edge) begin
            io_out_ff  <= top_bits(cur_byte, lanes_ff);
            io_oe_ff   <= oe_mask(lanes_ff);
            out_sh_ff  <= cur_byte << lanes_ff;
            out_cnt_ff <= load ? byte_edges : out_cnt_ff - 3'h1;
        end
    end

    xip_byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .flush     (cs_rise),
        .in_valid  (rd_valid),
        .in_ready  (rd_ready),
        .in_data   (rd_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data)
    );

    assign rd_addr          = rd_addr_ff;
    assign rd_addr_valid    = rd_addr_valid_ff;
    assign io_out           = io_out_ff;
    assign io_oe            = io_oe_ff;
    assign execute_in_place = xip_ff;
    assign vcr_xip_bit      = vcr_ff;

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_conf_one;
        conf_sample && xip_ff && conf;
    endsequence

    sequence s_conf_zero;
        conf_sample && xip_ff && !conf;
    endsequence

    sequence s_addr_done;
        state_ff == xip_pkg::ST_ADDR ##1 state_ff == xip_pkg::ST_DUMMY;
    endsequence

    a_confirm_exit: assert property (s_conf_one |=> !xip_ff && vcr_ff)
        else $error("confirm one did not leave xip");
    a_confirm_keep: assert property (s_conf_zero |=> xip_ff ##1 xip_ff)
        else $error("confirm zero did not keep xip");
    a_basic_entry: assert property (conf_sample && !xip_ff && !conf && cfg.basic_xip
                                    |=> xip_ff)
        else $error("basic variant did not enter xip");
    a_volatile_gate: assert property (conf_sample && !xip_ff && vcr_ff && !cfg.basic_xip
                                      |=> !xip_ff)
        else $error("xip entered without volatile enable");
    a_no_opcode: assert property (cs_fall && xip_ff && !hwrst_act
                                  |=> state_ff == xip_pkg::ST_ADDR)
        else $error("xip select did not start at address");
    a_pin_reset: assert property (hwrst_act && boot_done_ff
                                  |=> xip_ff == $past(nvcr_on) && vcr_ff &&
                                      state_ff == xip_pkg::ST_IDLE)
        else $error("reset pin did not restore boot state");
    a_reset_gated: assert property (cs_act && !conf_sample && boot_done_ff
                                    |=> $stable(xip_ff))
        else $error("xip changed while selected outside confirm");
    a_boot_state: assert property (!boot_done_ff |=> xip_ff == $past(nvcr_on))
        else $error("boot xip state wrong");
    a_lane_drive: assert property (drive_edge |=> io_oe_ff == oe_mask(lanes_ff))
        else $error("data lanes not enabled as protocol asks");
    a_addr_pulse: assert property (s_addr_done |-> rd_addr_valid_ff ##1 !rd_addr_valid_ff)
        else $error("address pulse missing or too long");
    a_recover_soft: assert property (s_conf_one |=> state_ff != xip_pkg::ST_IDLE)
        else $error("recovery reset the transfer");
endmodule

`default_nettype wire

// ===== tb/spi_host_model.sv
// Purpose: spi host model issuing fast reads and recovery frames
// Assumes: serial clock half period 32 ns, stands still outside frames
// Notes:   lines the host has released show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output var  logic       sclk,
    output var  logic       cs_n,
    output var  logic [3:0] io,
    input  wire logic [3:0] io_out
);
    // ********************
    // frame tasks
    // ********************
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io   = 4'h0;
    end

    // select held by hand, for pin pulses outside a frame
    task automatic sel(input logic v);
        cs_n = v;
    endtask

    task automatic tick(input logic [3:0] v);
        io = v;
        #32 sclk = 1'b1;
        #32 sclk = 1'b0;
    endtask

    task automatic xfer(input logic [31:0] hdr, input int nb, input int ln,
                        input logic [3:0] conf, input int dum, input int nby,
                        output logic [15:0] got);
        int i;
        logic [3:0] m;
        m = 4'((1 << ln) - 1);
        got = 16'h0000;
        cs_n = 1'b0;
        for (i = nb; i > 0; i -= ln) begin
            tick(4'(hdr >> (i - ln)) & m);
        end
        tick(conf);
        for (i = 1; i < dum; i++) begin
            tick(~io);
        end
        for (i = 0; i < nby * 8; i += ln) begin
            io = ~io;
            #32 sclk = 1'b1;
            got = (got << ln) | 16'((ln == 1) ? {3'h0, io_out[1]} : (io_out & m));
            #32 sclk = 1'b0;
        end
        // deselect before any further clock ends the recovery frame
        #32 cs_n = 1'b1;
        io = ~io;
        #200;
    endtask
endmodule
`default_nettype wire

// ===== tb/serial_flash_xip_read_mode_tb_top.sv
// Purpose: self-checking bench of the execute-in-place read engine
// Assumes: host model drives the serial pins
// Notes:   expected mode and enable bit come from a small integer model
`timescale 1ns/10ps
`default_nettype none
`include "xip_consts.svh"
module serial_flash_xip_read_mode_tb_top;
    logic           sys_clk;
    logic           reset_n;
    logic           sclk;
    logic           cs_n;
    logic           hw_rst_n;
    logic [3:0]     io;
    xip_pkg::pins_t pins;
    xip_pkg::cfg_t  cfg;
    logic           vcr_wr;
    logic           vcr_wr_xip;
    logic [7:0]     rd_data;
    logic           rd_valid;
    logic           rd_ready;
    logic [23:0]    rd_addr;
    logic           rd_addr_valid;
    logic [3:0]     io_out;
    logic [3:0]     io_oe;
    logic           execute_in_place;
    logic           vcr_xip_bit;
    int             err_count;
    int             comparisons;
    int             m_xip;
    int             m_vcr;
    int             k;
    int             n_addr;
    int             m_addr;
    logic [3:0]     last_oe;

    assign pins = {sclk, cs_n, hw_rst_n, io};

    // outputs looked at mid-cycle, well clear of the launching edge
    always @(negedge sys_clk) begin
        if (io_oe !== 4'h0) last_oe = io_oe;
        if (rd_addr_valid === 1'b1) n_addr++;
    end

    xip_read_engine DUT (.sys_clk(sys_clk), .reset_n(reset_n), .pins(pins), .cfg(cfg),
        .vcr_wr(vcr_wr), .vcr_wr_xip(vcr_wr_xip), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_addr_valid(rd_addr_valid),
        .io_out(io_out), .io_oe(io_oe), .execute_in_place(execute_in_place),
        .vcr_xip_bit(vcr_xip_bit));

    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .io(io), .io_out(io_out));

    // ********************
    // clock, watchdog, helpers
    // ********************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    task automatic wrap_up();
        $display("errors %0d of %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic chk_mode();
        chk({23'h0, execute_in_place}, 24'(m_xip), "mode");
        chk({23'h0, vcr_xip_bit}, 24'(m_vcr), "enable bit");
    endtask

    task automatic vcr(input logic v);
        @(posedge sys_clk) #1 vcr_wr = 1'b1;
        vcr_wr_xip = v;
        @(posedge sys_clk) #1 vcr_wr = 1'b0;
        @(posedge sys_clk) #1 m_vcr = v;
        chk_mode();
    endtask

    // one frame; confirm level on line0 drives the model
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int ln,
                      input logic [3:0] cf, input int dum, input int nby);
        logic [15:0] g;
        logic [7:0]  b;
        logic [3:0]  eo;
        b = 8'($urandom);
        eo = (ln == 4) ? `OE_LANES_4 : (ln == 2) ? `OE_LANES_2 : `OE_LANES_1;
        last_oe = 4'h0;
        m_addr++;
        @(posedge sys_clk) #1 rd_data = b;
        rd_valid = 1'b1;
        fork
            if (m_xip != 0) host.xfer({8'h00, a}, 24, ln, cf, dum, nby, g);
            else host.xfer({op, a}, 32, ln, cf, dum, nby, g);
            // stop offering before the deselect flush, or stale bytes refill the fifo
            begin
                @(posedge cs_n);
                @(posedge sys_clk) #1 rd_valid = 1'b0;
            end
        join
        @(posedge sys_clk) #1;
        chk(rd_addr, a, "address");
        chk(24'(n_addr), 24'(m_addr), "address pulses");
        chk({20'h0, io_oe}, 24'h0, "lanes released");
        chk({23'h0, rd_ready}, 24'h1, "fifo ready");
        if (nby == 1) chk({8'h00, g}, {16'h0000, b}, "read data");
        if (nby == 1) chk({20'h0, last_oe}, {20'h0, eo}, "lane enables");
        if (m_xip != 0) begin
            m_xip = cf[0] ? 0 : 1;
            if (cf[0]) m_vcr = 1;
        end else if (!cf[0] && (m_vcr == 0 || cfg.basic_xip)) m_xip = 1;
        chk_mode();
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        reset_n = 1'b0;
        hw_rst_n = 1'b1;
        cfg = {`MODE_SINGLE, 1'b0, `NVCR_XIP_OFF, 1'b1, 4'h8};
        vcr_wr = 1'b0;
        vcr_wr_xip = 1'b1;
        rd_data = 8'h00;
        rd_valid = 1'b0;
        m_xip = 0;
        m_vcr = 1;
        void'($urandom(67));
        repeat (2) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk_mode();
        rd(`CMD_FAST_READ, 24'h123456, 1, 4'h0, 8, 1);
        vcr(1'b0);
        rd(`CMD_FAST_READ, 24'hA5A5A5, 1, 4'h0, 8, 1);
        for (k = 0; k < 2; k++) rd(8'h00, 24'($urandom), 1, 4'h0, 8, 1);
        rd(8'h00, 24'h0F0F0F, 1, 4'h1, 8, 0);
        vcr(1'b0);
        rd(`CMD_FAST_READ, 24'h000010, 1, 4'h0, 8, 0);
        rd(8'h00, 24'hFFFFFF, 1, 4'h1, 1, 0);
        @(posedge sys_clk) #1 cfg.protocol = `MODE_QUAD;
        cfg.basic_xip = 1'b1;
        rd(`CMD_QUAD_IO, 24'h345678, 4, 4'hE, 8, 0);
        rd(8'h00, 24'h9ABCDE, 4, 4'h1, 8, 1);
        @(posedge sys_clk) #1 cfg.protocol = `MODE_DUAL;
        rd(`CMD_DUAL_IO, 24'($urandom), 2, 4'h2, 8, 1);
        rd(8'h00, 24'hFFFFFF, 2, 4'h1, 1, 0);
        @(posedge sys_clk) #1 cfg.protocol = `MODE_SINGLE;
        cfg.basic_xip = 1'b0;
        vcr(1'b0);
        rd(`CMD_FAST_READ, 24'h000020, 1, 4'h0, 8, 0);
        host.sel(1'b0);
        #40 hw_rst_n = 1'b0;
        #80 hw_rst_n = 1'b1;
        #40 host.sel(1'b1);
        #100 chk_mode();
        @(posedge sys_clk) #1 hw_rst_n = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1 hw_rst_n = 1'b1;
        m_xip = 0;
        m_vcr = 1;
        repeat (8) @(posedge sys_clk);
        #1 chk_mode();
        cfg.nvcr_xip = 3'h2;
        reset_n = 1'b0;
        @(posedge sys_clk) #1 reset_n = 1'b1;
        m_xip = 1;
        repeat (4) @(posedge sys_clk);
        #1 chk_mode();
        rd(8'h00, 24'h00ABCD, 1, 4'h0, 8, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
